// File: core/ppwh_defs.svh
// constants for the parallel ports with strobe handshake
// assumes the includer imports nothing else under these names
//
// Operation
// - direction bit: 0 input, 1 output; reset clears
// - port three direction from bit zero only
// - expanded modes: port three is data bus
// - port four per-pin direction; expanded: upper address
// - mode one forces port four address outputs
// - port five per-pin direction
// - pins four, five steered by handshake register
// - enable bits make pins zero, one interrupts
// - either wait bit selects pin two; mode three inhibits
// - auto wait: one stretch per external access
// - manual: pin controls; both: stretch only if low
// - halt enable selects pin three; resets to one
// - clearing standby bit enters standby; pin low blocks
// - ram enable bit, resets to one
// - supply kept bit cleared on supply loss
// - port six per-pin direction
// - latch on strobe fall; port six read clears
// - select bit: write or read launches strobe
// - strobe enable makes pin five output strobe
// - strobe flag sets on fall; armed access clears
// - strobe interrupt enable raises first interrupt
`ifndef PPWH_DEFS_SVH
`define PPWH_DEFS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define PPWH_OFS_P3_DIR 8'h04
`define PPWH_OFS_P4_DIR 8'h05
`define PPWH_OFS_P3_DATA 8'h06
`define PPWH_OFS_P4_DATA 8'h07
`define PPWH_OFS_RP5_CTL 8'h14
`define PPWH_OFS_P5_DATA 8'h15
`define PPWH_OFS_P6_DIR 8'h16
`define PPWH_OFS_P6_DATA 8'h17
`define PPWH_OFS_P5_DIR 8'h20
`define PPWH_OFS_HS_CSR 8'h21

// ************************************************************
// ram/port five control fields and reset
// ************************************************************
`define PPWH_B_INT1 0
`define PPWH_B_INT2 1
`define PPWH_B_MWAIT 2
`define PPWH_B_HALT 3
`define PPWH_B_AWAIT 4
`define PPWH_B_STANDBY_PIN 5
`define PPWH_B_RAM 6
`define PPWH_B_SUPPLY 7
`define PPWH_RP5_RESET 8'h78

// ************************************************************
// handshake control/status fields
// ************************************************************
`define PPWH_B_LATCH 3
`define PPWH_B_OSE 4
`define PPWH_B_OSS 5
`define PPWH_B_SIE 6
`define PPWH_B_FLAG 7

// ************************************************************
// mode pin codes
// ************************************************************
`define PPWH_MODE1 2'h1
`define PPWH_MODE2 2'h2
`define PPWH_MODE3 2'h3

`endif

// File: core/ppwh_pkg.sv
// types shared by the port block
// assumes ppwh_defs.svh holds the numbers
package ppwh_pkg;
	// operating mode taken from the mode pins
	typedef logic [1:0] ppwh_mode_t;
	// byte-wide port value
	typedef logic [7:0] ppwh_byte_t;
endpackage : ppwh_pkg

// File: core/ppwh_hs_if.sv
// handshake signals between the port block and its strobe unit
// assumes both ends run on core_clk
`timescale 1ns/1ps
interface ppwh_hs_if;
	import ppwh_pkg::*;
	logic rd_data;
	logic wr_data;
	logic rd_csr;
	logic latch_en;
	logic strobe_sel;
	logic strobe_n_sync;
	ppwh_byte_t pins_sync;
	logic flag;
	logic latch_full;
	ppwh_byte_t latch_data;
	logic strobe_n;
	modport ctrl (output rd_data, wr_data, rd_csr, latch_en, strobe_sel,
		strobe_n_sync, pins_sync, input flag, latch_full, latch_data,
		strobe_n);
	modport unit (input rd_data, wr_data, rd_csr, latch_en, strobe_sel,
		strobe_n_sync, pins_sync, output flag, latch_full, latch_data,
		strobe_n);
endinterface : ppwh_hs_if

// File: core/ppwh_strobe.sv
// port six strobe unit: input latch, strobe flag, output strobe
// assumes inputs already synchronised to core_clk
`timescale 1ns/1ps
`include "ppwh_defs.svh"
module ppwh_strobe
	import ppwh_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	ppwh_hs_if.unit hs
);
	logic strobe_prev;
	logic armed;
	logic fall;
	logic access;

	// ************************************************************
	// edge detect on the synchronised input strobe
	// ************************************************************
	assign fall = strobe_prev & ~hs.strobe_n_sync;
	assign access = hs.rd_data | hs.wr_data;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			strobe_prev <= 1'b1;
		end else begin
			strobe_prev <= hs.strobe_n_sync;
		end
	end

	// latch captures on fall; a port read empties it
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			hs.latch_full <= 1'b0;
			hs.latch_data <= 8'h00;
		end else if (hs.latch_en && fall) begin
			hs.latch_full <= 1'b1;
			hs.latch_data <= hs.pins_sync;
		end else if (hs.rd_data || !hs.latch_en) begin
			hs.latch_full <= 1'b0;
		end
	end

	// flag: set beats the armed clear in the same cycle
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			hs.flag <= 1'b0;
			armed <= 1'b0;
		end else begin
			if (fall) begin
				hs.flag <= 1'b1;
			end else if (armed && access) begin
				hs.flag <= 1'b0;
			end
			if (hs.rd_csr) begin
				armed <= hs.flag;
			end else if (access) begin
				armed <= 1'b0;
			end
		end
	end

	// one low cycle right after the launching access
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			hs.strobe_n <= 1'b1;
		end else begin
			hs.strobe_n <= ~(hs.strobe_sel ? hs.wr_data : hs.rd_data);
		end
	end
endmodule : ppwh_strobe

// File: core/ppwh_ports.sv
// parallel ports three to six with handshake, main module
// assumes a single-cycle register port and pins from outside
`timescale 1ns/1ps
`include "ppwh_defs.svh"
module ppwh_ports
	import ppwh_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [1:0] mode_pin,
	input wire logic standby_pin_n,
	input wire logic supply_lost,
	input wire logic [7:0] p3_in,
	output logic [7:0] p3_out,
	output logic [7:0] p3_oe,
	input wire logic [7:0] p4_in,
	output logic [7:0] p4_out,
	output logic [7:0] p4_oe,
	input wire logic [7:0] p5_in,
	output logic [7:0] p5_out,
	output logic [7:0] p5_oe,
	input wire logic [7:0] p6_in,
	output logic [7:0] p6_out,
	output logic [7:0] p6_oe,
	input wire logic [7:0] ext_addr_hi,
	input wire logic [7:0] ext_wdata,
	input wire logic ext_write,
	input wire logic ext_access,
	output logic [7:0] ext_rdata,
	output logic e_stretch,
	output logic external_int1,
	output logic external_int2,
	output logic halt_req,
	output logic standby_mode,
	output logic onchip_ram_on
);
	// ************************************************************
	// decode helpers
	// ************************************************************
	function automatic logic is_expanded(input ppwh_mode_t m);
		is_expanded = (m == `PPWH_MODE1) || (m == `PPWH_MODE2);
	endfunction : is_expanded

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction : hit

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	ppwh_byte_t p3_m, p3_s, p4_m, p4_s, p5_m, p5_s, p6_m, p6_s;
	logic [1:0] mode_m;
	ppwh_mode_t mode;
	logic standby_pin_m, standby_pin_s, lost_m, lost_s;

	// two stages; only the second is read by logic
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			p3_m <= 8'hFF;
			p3_s <= 8'hFF;
			p4_m <= 8'hFF;
			p4_s <= 8'hFF;
			p5_m <= 8'hFF;
			p5_s <= 8'hFF;
			p6_m <= 8'hFF;
			p6_s <= 8'hFF;
			mode_m <= `PPWH_MODE3;
			mode <= `PPWH_MODE3;
			standby_pin_m <= 1'b1;
			standby_pin_s <= 1'b1;
			lost_m <= 1'b0;
			lost_s <= 1'b0;
		end else begin
			p3_m <= p3_in;
			p3_s <= p3_m;
			p4_m <= p4_in;
			p4_s <= p4_m;
			p5_m <= p5_in;
			p5_s <= p5_m;
			p6_m <= p6_in;
			p6_s <= p6_m;
			mode_m <= mode_pin;
			mode <= mode_m;
			standby_pin_m <= standby_pin_n;
			standby_pin_s <= standby_pin_m;
			lost_m <= supply_lost;
			lost_s <= lost_m;
		end
	end

	// ************************************************************
	// software registers
	// ************************************************************
	logic p3_dir;
	ppwh_byte_t p4_dir, p5_dir, p6_dir;
	ppwh_byte_t p3_data, p4_data, p5_data, p6_data;
	ppwh_byte_t rp5;
	logic latch_en, strobe_pin_enable, strobe_on_write_select, sie;
	logic expanded;
	logic wr_rp5;
	logic wait_sel, halt_sel, mwait, await_on, wait_low;

	assign expanded = is_expanded(mode);
	assign wr_rp5 = reg_wr && hit(reg_addr, `PPWH_OFS_RP5_CTL);

	// direction registers clear at reset: all pins inputs
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			p3_dir <= 1'b0;
			p4_dir <= 8'h00;
			p5_dir <= 8'h00;
			p6_dir <= 8'h00;
		end else if (reg_wr) begin
			if (hit(reg_addr, `PPWH_OFS_P3_DIR)) begin
				p3_dir <= reg_wdata[0];
			end
			if (hit(reg_addr, `PPWH_OFS_P4_DIR)) begin
				p4_dir <= reg_wdata;
			end
			if (hit(reg_addr, `PPWH_OFS_P5_DIR)) begin
				p5_dir <= reg_wdata;
			end
			if (hit(reg_addr, `PPWH_OFS_P6_DIR)) begin
				p6_dir <= reg_wdata;
			end
		end
	end

	// output data registers
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			p3_data <= 8'h00;
			p4_data <= 8'h00;
			p5_data <= 8'h00;
			p6_data <= 8'h00;
		end else if (reg_wr) begin
			if (hit(reg_addr, `PPWH_OFS_P3_DATA)) begin
				p3_data <= reg_wdata;
			end
			if (hit(reg_addr, `PPWH_OFS_P4_DATA)) begin
				p4_data <= reg_wdata;
			end
			if (hit(reg_addr, `PPWH_OFS_P5_DATA)) begin
				p5_data <= reg_wdata;
			end
			if (hit(reg_addr, `PPWH_OFS_P6_DATA)) begin
				p6_data <= reg_wdata;
			end
		end
	end

	// ram/port five control; supply bit is cleared by loss
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rp5 <= `PPWH_RP5_RESET;
		end else begin
			if (wr_rp5) begin
				rp5[`PPWH_B_STANDBY_PIN - 1:0] <= reg_wdata[`PPWH_B_STANDBY_PIN - 1:0];
				rp5[`PPWH_B_RAM] <= reg_wdata[`PPWH_B_RAM];
				// a low standby pin blocks entering standby
				if (reg_wdata[`PPWH_B_STANDBY_PIN] || standby_pin_s) begin
					rp5[`PPWH_B_STANDBY_PIN] <= reg_wdata[`PPWH_B_STANDBY_PIN];
				end
			end
			// loss wins over a software write
			if (lost_s) begin
				rp5[`PPWH_B_SUPPLY] <= 1'b0;
			end else if (wr_rp5) begin
				rp5[`PPWH_B_SUPPLY] <= reg_wdata[`PPWH_B_SUPPLY];
			end
		end
	end

	// handshake control bits
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			latch_en <= 1'b0;
			strobe_pin_enable <= 1'b0;
			strobe_on_write_select <= 1'b0;
			sie <= 1'b0;
		end else if (reg_wr && hit(reg_addr, `PPWH_OFS_HS_CSR)) begin
			latch_en <= reg_wdata[`PPWH_B_LATCH];
			strobe_pin_enable <= reg_wdata[`PPWH_B_OSE];
			strobe_on_write_select <= reg_wdata[`PPWH_B_OSS];
			sie <= reg_wdata[`PPWH_B_SIE];
		end
	end

	// ************************************************************
	// strobe unit
	// ************************************************************
	ppwh_hs_if hs ();

	assign hs.rd_data = reg_rd && hit(reg_addr, `PPWH_OFS_P6_DATA);
	assign hs.wr_data = reg_wr && hit(reg_addr, `PPWH_OFS_P6_DATA);
	assign hs.rd_csr = reg_rd && hit(reg_addr, `PPWH_OFS_HS_CSR);
	assign hs.latch_en = latch_en;
	assign hs.strobe_sel = strobe_on_write_select;
	assign hs.strobe_n_sync = p5_s[4];
	assign hs.pins_sync = p6_s;

	ppwh_strobe u_strobe (
		.core_clk(core_clk),
		.reset(reset),
		.hs(hs)
	);

	// ************************************************************
	// read data, one cycle after the strobe
	// ************************************************************
	ppwh_byte_t next_rdata;
	ppwh_byte_t p6_view;

	// a full latch stands in for the input pins of port six
	assign p6_view = hs.latch_full ? hs.latch_data : p6_s;

	always_comb begin
		next_rdata = 8'h00;
		case (reg_addr)
			`PPWH_OFS_P3_DIR: next_rdata = {7'h00, p3_dir};
			`PPWH_OFS_P4_DIR: next_rdata = p4_dir;
			`PPWH_OFS_P5_DIR: next_rdata = p5_dir;
			`PPWH_OFS_P6_DIR: next_rdata = p6_dir;
			`PPWH_OFS_P3_DATA: next_rdata = p3_dir ? p3_data : p3_s;
			`PPWH_OFS_P4_DATA:
				next_rdata = (p4_dir & p4_data) | (~p4_dir & p4_s);
			`PPWH_OFS_P5_DATA:
				next_rdata = (p5_dir & p5_data) | (~p5_dir & p5_s);
			`PPWH_OFS_P6_DATA:
				next_rdata = (p6_dir & p6_data) | (~p6_dir & p6_view);
			`PPWH_OFS_RP5_CTL: next_rdata = rp5;
			`PPWH_OFS_HS_CSR:
				next_rdata = {hs.flag, sie, strobe_on_write_select, strobe_pin_enable, latch_en, 3'h0};
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ************************************************************
	// pin drive
	// ************************************************************
	ppwh_byte_t next_p3_out, next_p3_oe, next_p4_out, next_p4_oe;
	ppwh_byte_t next_p5_out, next_p5_oe;

	// ports three and four: general I/O or external bus
	always_comb begin
		if (expanded) begin
			next_p3_out = ext_wdata;
			next_p3_oe = {8{ext_write}};
		end else begin
			next_p3_out = p3_data;
			next_p3_oe = {8{p3_dir}};
		end
		if (mode == `PPWH_MODE1) begin
			next_p4_out = ext_addr_hi;
			next_p4_oe = 8'hFF;
		end else if (mode == `PPWH_MODE2) begin
			next_p4_out = ext_addr_hi;
			next_p4_oe = p4_dir;
		end else begin
			next_p4_out = p4_data;
			next_p4_oe = p4_dir;
		end
	end

	// port five: control roles turn pins zero to four into inputs, pin five into strobe output
	always_comb begin
		next_p5_out = p5_data;
		next_p5_oe = p5_dir;
		if (rp5[`PPWH_B_INT1]) begin
			next_p5_oe[0] = 1'b0;
		end
		if (rp5[`PPWH_B_INT2]) begin
			next_p5_oe[1] = 1'b0;
		end
		if (wait_sel) begin
			next_p5_oe[2] = 1'b0;
		end
		if (halt_sel) begin
			next_p5_oe[3] = 1'b0;
		end
		if (latch_en) begin
			next_p5_oe[4] = 1'b0;
		end
		if (strobe_pin_enable) begin
			next_p5_out[5] = hs.strobe_n;
			next_p5_oe[5] = 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			p3_out <= 8'h00;
			p3_oe <= 8'h00;
			p4_out <= 8'h00;
			p4_oe <= 8'h00;
			p5_out <= 8'h00;
			p5_oe <= 8'h00;
			p6_out <= 8'h00;
			p6_oe <= 8'h00;
			ext_rdata <= 8'h00;
		end else begin
			p3_out <= next_p3_out;
			p3_oe <= next_p3_oe;
			p4_out <= next_p4_out;
			p4_oe <= next_p4_oe;
			p5_out <= next_p5_out;
			p5_oe <= next_p5_oe;
			p6_out <= p6_data;
			p6_oe <= p6_dir;
			ext_rdata <= p3_s;
		end
	end

	// ************************************************************
	// wait, halt, interrupts and power
	// ************************************************************
	// selects sit with the registers: the pin logic above reads them

	assign mwait = rp5[`PPWH_B_MWAIT];
	assign await_on = rp5[`PPWH_B_AWAIT];
	// mode three never waits or halts
	assign wait_sel = (mwait | await_on) & (mode != `PPWH_MODE3);
	assign halt_sel = rp5[`PPWH_B_HALT] & (mode != `PPWH_MODE3);
	assign wait_low = ~p5_s[2];

	// stretch: one cycle per access in auto, pin level in manual
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			e_stretch <= 1'b0;
		end else if (!wait_sel) begin
			e_stretch <= 1'b0;
		end else if (await_on && !mwait) begin
			e_stretch <= ext_access;
		end else if (mwait && !await_on) begin
			e_stretch <= wait_low;
		end else begin
			e_stretch <= ext_access & wait_low;
		end
	end

	// requests are active high; pins are active low
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			external_int1 <= 1'b0;
			external_int2 <= 1'b0;
			halt_req <= 1'b0;
			standby_mode <= 1'b0;
			onchip_ram_on <= 1'b1;
		end else begin
			external_int1 <= (rp5[`PPWH_B_INT1] & ~p5_s[0])
				| (sie & hs.flag);
			external_int2 <= rp5[`PPWH_B_INT2] & ~p5_s[1];
			halt_req <= halt_sel & ~p5_s[3];
			standby_mode <= ~rp5[`PPWH_B_STANDBY_PIN];
			onchip_ram_on <= rp5[`PPWH_B_RAM];
		end
	end
endmodule : ppwh_ports

// File: verification/ppwh_ports_properties.sv
// checker for the port block, top ports only
// assumes binding to ppwh_ports and a steady mode between tests
`timescale 1ns/1ps
module ppwh_ports_chk (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [1:0] mode_pin,
	input wire logic standby_pin_n,
	input wire logic [7:0] p3_oe,
	input wire logic [7:0] p4_oe,
	input wire logic [7:0] p5_in,
	input wire logic [7:0] p5_out,
	input wire logic [7:0] p5_oe,
	input wire logic [7:0] p6_oe,
	input wire logic ext_access,
	input wire logic e_stretch,
	input wire logic external_int1,
	input wire logic halt_req,
	input wire logic standby_mode,
	input wire logic onchip_ram_on
);
	// ************************************************************
	// shadows of mode and control bits
	// ************************************************************
	logic [1:0] mode_q1, mode_q2;
	logic [7:0] rp5_sh, csr_sh;
	// two flops, as the design syncs the mode pins
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			mode_q1 <= 2'h3;
			mode_q2 <= 2'h3;
		end else begin
			mode_q1 <= mode_pin;
			mode_q2 <= mode_q1;
		end
	end
	// only enable bits are used, so blocked writes do not matter
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rp5_sh <= 8'h78;
			csr_sh <= 8'h00;
		end else if (reg_wr) begin
			if (reg_addr == 8'h14) rp5_sh <= reg_wdata;
			if (reg_addr == 8'h21) csr_sh <= reg_wdata;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	sequence strobing_access;
		reg_addr == 8'h17 && csr_sh[4]
			&& ((reg_wr && csr_sh[5]) || (reg_rd && !csr_sh[5]));
	endsequence
	sequence strobe_pulse;
		##2 !p5_out[5] ##1 p5_out[5];
	endsequence
	AST_RESET_STATE: assert property (
		$fell(reset) |-> onchip_ram_on && !standby_mode
			&& p3_oe == 8'h00 && p5_oe == 8'h00 && p6_oe == 8'h00)
		else $error("outputs wrong after reset");
	AST_P3_DIR: assert property (
		reg_wr && reg_addr == 8'h04 && mode_q2 == 2'h3 && mode_q1 == 2'h3
			|-> ##2 p3_oe == {8{$past(reg_wdata[0], 2)}})
		else $error("port three enable not from bit zero");
	AST_P4_MODE1: assert property (
		mode_q2 == 2'h1 && mode_q1 == 2'h1 |=> p4_oe == 8'hFF)
		else $error("port four not driven in mode one");
	AST_AUTO_WAIT: assert property (
		ext_access && rp5_sh[4] && !rp5_sh[2] && mode_q2 != 2'h3
			|=> e_stretch)
		else $error("auto stretch missing");
	AST_NO_WAIT: assert property (
		mode_q2 == 2'h3 || (!rp5_sh[4] && !rp5_sh[2]) |=> !e_stretch)
		else $error("stretch while inhibited");
	AST_HALT_MODE3: assert property (
		mode_q2 == 2'h3 |=> !halt_req)
		else $error("halt in single chip mode");
	AST_STANDBY_HOLD: assert property (
		(!standby_pin_n) [*6] ##0 !standby_mode |=> !standby_mode)
		else $error("standby entered with pin low");
	AST_OUT_STROBE: assert property (
		strobing_access |-> strobe_pulse)
		else $error("output strobe not one cycle low");
	AST_STROBE_INT: assert property (
		$fell(p5_in[4]) && csr_sh[6] && csr_sh[3] |-> ##[1:6] external_int1)
		else $error("strobe interrupt missing");
	AST_NO_INT1: assert property (
		(!rp5_sh[0] && !csr_sh[6]) [*3] |-> !external_int1)
		else $error("interrupt one without enable");
endmodule : ppwh_ports_chk
bind ppwh_ports ppwh_ports_chk u_chk (.core_clk, .reset, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .mode_pin, .standby_pin_n, .p3_oe,
	.p4_oe, .p5_in, .p5_out, .p5_oe, .p6_oe, .ext_access, .e_stretch,
	.external_int1, .halt_req, .standby_mode, .onchip_ram_on);

// File: verification/ppwh_periph.sv
// far-side model: pins of ports five and six
// assumes pull-ups on every pin that nobody drives
`timescale 1ns/1ps
module ppwh_periph (
	input wire logic core_clk,
	input wire logic [7:0] p5_out,
	input wire logic [7:0] p5_oe,
	input wire logic [7:0] p6_out,
	input wire logic [7:0] p6_oe,
	input wire logic [3:0] pull_low,
	output logic [7:0] p5_in,
	output logic [7:0] p6_in,
	output int os_count
);
	logic strobe_n = 1'b1;
	logic prev_os = 1'b1;
	logic [7:0] data_drv = 8'hFF;
	int n_falls = 0;
	assign os_count = n_falls;
	// design drive wins, else this model, else pull-up
	assign p5_in = (p5_oe & p5_out) | (~p5_oe & {3'h7, strobe_n, ~pull_low});
	assign p6_in = (p6_oe & p6_out) | (~p6_oe & data_drv);
	// count falls of the output strobe while it is driven
	always @(posedge core_clk) begin
		prev_os <= p5_out[5] | ~p5_oe[5];
		if (prev_os && p5_oe[5] && !p5_out[5])
			n_falls <= n_falls + 1;
	end
	// data set up before the fall and held after the rise
	task send(input logic [7:0] d);
		@(posedge core_clk);
		data_drv <= d;
		repeat (2) @(posedge core_clk);
		strobe_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		strobe_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		data_drv <= 8'hFF;
	endtask : send
endmodule : ppwh_periph

// File: verification/testbench.sv
// self-checking bench for the port block
// assumes design, checker and far-side model compiled first
`timescale 1ns/1ps
module testbench;
	import ppwh_pkg::*;
	logic core_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic standby_pin_n = 1'b1, supply_lost = 1'b0;
	logic ext_write = 1'b0, ext_access = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	logic [1:0] mode_pin = 2'h3;
	logic [3:0] pull_low = 4'h0;
	ppwh_byte_t reg_rdata, p3_out, p3_oe, p4_out, p4_oe, p5_in, p5_out;
	ppwh_byte_t p5_oe, p6_in, p6_out, p6_oe, ext_rdata;
	logic e_stretch, external_int1, external_int2, halt_req;
	logic standby_mode, onchip_ram_on;
	int n_mismatch = 0, compares = 0, n0;
	logic [7:0] dir_ofs [4] = '{8'h04, 8'h05, 8'h16, 8'h20};
	logic [7:0] dir_val [4] = '{8'h01, 8'h3C, 8'h5A, 8'hC3};
	always #25 core_clk = ~core_clk;
	ppwh_ports DUT (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .mode_pin, .standby_pin_n, .supply_lost,
		.p3_in(8'h5A), .p3_out, .p3_oe, .p4_in(8'hA5), .p4_out, .p4_oe,
		.p5_in, .p5_out, .p5_oe, .p6_in, .p6_out, .p6_oe,
		.ext_addr_hi(8'hC3), .ext_wdata(8'h96), .ext_write, .ext_access,
		.ext_rdata, .e_stretch, .external_int1, .external_int2, .halt_req,
		.standby_mode, .onchip_ram_on);
	ppwh_periph periph (.core_clk, .p5_out, .p5_oe, .p6_out, .p6_oe,
		.pull_low, .p5_in, .p6_in, .os_count());
	// ************************************************************
	// access and compare tasks
	// ************************************************************
	task automatic chk(input string what, input logic [7:0] e,
		input logic [7:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	// strobe held one edge, then an idle edge so calls never collide
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e,
		input string what);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		chk(what, e, reg_rdata);
	endtask : rd
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick
	task automatic pulse_access;
		ext_access <= 1'b1;
		tick(1);
		ext_access <= 1'b0;
		tick(1);
	endtask : pulse_access
	task automatic tally_and_finish;
		if (n_mismatch == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	// ************************************************************
	// watchdog and test sequence
	// ************************************************************
	initial begin
		#100000;
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		tick(6);
		reset <= 1'b0;
		tick(3);
		rd(8'h14, 8'h78, "rp5 reset");
		rd(8'h21, 8'h00, "csr reset");
		rd(8'h3F, 8'h00, "unmapped");
		for (int i = 0; i < 4; i++) begin
			rd(dir_ofs[i], 8'h00, "dir reset");
			wr(dir_ofs[i], dir_val[i]);
			rd(dir_ofs[i], dir_val[i], "dir back");
		end
		chk("p3 oe", 8'hFF, p3_oe);
		chk("p4 oe", 8'h3C, p4_oe);
		chk("p6 oe", 8'h5A, p6_oe);
		chk("p5 oe", 8'hC3, p5_oe);
		wr(8'h06, 8'h69);
		rd(8'h06, 8'h69, "p3 data");
		chk("p3 out", 8'h69, p3_out);
		rd(8'h07, 8'h81, "p4 data");
		wr(8'h15, 8'hA5);
		rd(8'h15, 8'hBD, "p5 data");
		wr(8'h04, 8'hFE);
		tick(1);
		chk("p3 oe bit0", 8'h00, p3_oe);
		mode_pin <= 2'h1;
		ext_write <= 1'b1;
		tick(4);
		chk("p4 oe mode1", 8'hFF, p4_oe);
		chk("p4 addr", 8'hC3, p4_out);
		chk("p3 bus oe", 8'hFF, p3_oe);
		chk("p3 bus data", 8'h96, p3_out);
		ext_write <= 1'b0;
		tick(4);
		chk("p3 bus in", 8'h5A, ext_rdata);
		pulse_access();
		chk("auto wait", 8'h01, 8'(e_stretch));
		tick(1);
		chk("auto wait end", 8'h00, 8'(e_stretch));
		pull_low <= 4'h8;
		tick(5);
		chk("halt", 8'h01, 8'(halt_req));
		wr(8'h14, 8'h6C);
		pull_low <= 4'h4;
		tick(5);
		chk("manual wait", 8'h01, 8'(e_stretch));
		pull_low <= 4'h0;
		wr(8'h14, 8'h7C);
		tick(4);
		pulse_access();
		chk("both pin high", 8'h00, 8'(e_stretch));
		pull_low <= 4'h4;
		tick(4);
		pulse_access();
		chk("both pin low", 8'h01, 8'(e_stretch));
		pull_low <= 4'h0;
		mode_pin <= 2'h2;
		wr(8'h05, 8'h0F);
		tick(3);
		chk("p4 oe mode2", 8'h0F, p4_oe);
		mode_pin <= 2'h3;
		wr(8'h14, 8'h18);
		tick(3);
		chk("standby", 8'h01, 8'(standby_mode));
		chk("ram off", 8'h00, 8'(onchip_ram_on));
		wr(8'h14, 8'h78);
		standby_pin_n <= 1'b0;
		tick(3);
		wr(8'h14, 8'h58);
		rd(8'h14, 8'h78, "standby blocked");
		standby_pin_n <= 1'b1;
		wr(8'h14, 8'hF8);
		rd(8'h14, 8'hF8, "supply set");
		supply_lost <= 1'b1;
		tick(4);
		supply_lost <= 1'b0;
		rd(8'h14, 8'h78, "supply lost");
		wr(8'h14, 8'h7B);
		pull_low <= 4'h3;
		tick(5);
		chk("int1 pin", 8'h01, 8'(external_int1));
		chk("int2 pin", 8'h01, 8'(external_int2));
		pull_low <= 4'h0;
		wr(8'h14, 8'h78);
		wr(8'h16, 8'h00);
		wr(8'h21, 8'h78);
		periph.send(8'hA6);
		tick(2);
		chk("strobe int", 8'h01, 8'(external_int1));
		rd(8'h17, 8'hA6, "latched data");
		rd(8'h21, 8'hF8, "flag kept");
		rd(8'h17, 8'hFF, "latch freed");
		rd(8'h21, 8'h78, "flag clear");
		n0 = periph.os_count;
		wr(8'h17, 8'h3C);
		tick(2);
		chk("os write", 8'(n0 + 1), 8'(periph.os_count));
		chk("p6 out", 8'h3C, p6_out);
		wr(8'h21, 8'h58);
		wr(8'h17, 8'h3C);
		rd(8'h17, 8'hFF, "p6 pins");
		tick(2);
		chk("os read", 8'(n0 + 2), 8'(periph.os_count));
		tally_and_finish();
	end
endmodule : testbench
